// ### verilog/mbac_pkg.sv
`default_nettype none
package mbac_pkg;

  // ************************************************************
  // modes, operations, spaces and register groups
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_BOOT = 2'b00,
    MODE_TEST = 2'b01,
    MODE_ISO  = 2'b10,
    MODE_SYS  = 2'b11
  } mbac_mode_t;

  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_WRITE = 2'b01,
    OP_FETCH = 2'b10
  } mbac_op_t;

  typedef enum logic [2:0] {
    SP_ROM    = 3'b000,
    SP_EEPROM = 3'b001,
    SP_RAM    = 3'b010,
    SP_SECROW = 3'b011,
    SP_CRAM   = 3'b100
  } mbac_space_t;

  typedef enum logic [2:0] {
    GRP_NONE = 3'b000,
    GRP_GEN  = 3'b001,
    GRP_SYS  = 3'b010,
    GRP_FW   = 3'b011,
    GRP_HW   = 3'b100,
    GRP_TEST = 3'b101
  } mbac_group_t;

  // ************************************************************
  // fixed memory partitions: base and size per region
  // ************************************************************
  localparam logic [15:0] ROM_TEST_BASE   = 16'h0000;
  localparam logic [16:0] ROM_TEST_SIZE   = 17'h02000;
  localparam logic [15:0] ROM_APP_BASE    = 16'h2000;
  localparam logic [16:0] ROM_APP_SIZE    = 17'h0E000;
  localparam logic [16:0] ROM_WHOLE_SIZE  = 17'h10000;
  localparam logic [15:0] EE_ISO_BASE     = 16'h0000;
  localparam logic [16:0] EE_ISO_SIZE     = 17'h01000;
  localparam logic [15:0] EE_SEC_BASE     = 16'h1000;
  localparam logic [16:0] EE_SEC_SIZE     = 17'h00080;
  localparam logic [15:0] EE_APP_BASE     = 16'h1080;
  localparam logic [16:0] EE_APP_SIZE     = 17'h0EF80;
  localparam logic [16:0] EE_WHOLE_SIZE   = 17'h10000;
  localparam logic [15:0] RAM_BOOT_BASE   = 16'h0000;
  localparam logic [16:0] RAM_BOOT_SIZE   = 17'h00100;
  localparam logic [15:0] RAM_APP_BASE    = 16'h0100;
  localparam logic [16:0] RAM_APP_SIZE    = 17'h00F00;
  localparam logic [16:0] RAM_WHOLE_SIZE  = 17'h01000;
  localparam logic [15:0] CRAM_BASE       = 16'h0000;
  localparam logic [16:0] CRAM_SIZE       = 17'h00200;

  // ************************************************************
  // special function register map
  // ************************************************************
  localparam logic [7:0] SFR_GEN_LO      = 8'h80;
  localparam logic [7:0] SFR_SYS_LO      = 8'hA0;
  localparam logic [7:0] SFR_FW_LO       = 8'hC0;
  localparam logic [7:0] SFR_HW_LO       = 8'hD0;
  localparam logic [7:0] SFR_TEST_LO     = 8'hF0;
  localparam logic [7:0] SFR_STATUS_HIGH = 8'hA0;
  localparam logic [7:0] SFR_POINTER_0   = 8'hA1;
  localparam logic [7:0] SFR_POINTER_2   = 8'hA3;
  localparam logic [7:0] SFR_FW_CTRL_LOW = 8'hC0;
  localparam logic [7:0] SFR_FW_CTRL_HI  = 8'hC1;
  localparam logic [7:0] SFR_CLOCK_SEL   = 8'hD0;
  localparam logic [7:0] SFR_RANDOM      = 8'hD1;
  localparam logic [7:0] SFR_HIDDEN_KEY  = 8'hD2;
  localparam int         STATUS_ISO_BIT  = 7;

  // ************************************************************
  // wishbone register offsets and reset values
  // ************************************************************
  localparam logic [7:0]  WB_STATUS_HIGH = 8'h00;
  localparam logic [7:0]  WB_FW_LOW      = 8'h04;
  localparam logic [7:0]  WB_FW_HIGH     = 8'h08;
  localparam logic [7:0]  WB_MODE        = 8'h0C;
  localparam logic [7:0]  WB_DENY_COUNT  = 8'h10;
  localparam logic [7:0]  WB_LAST_DENY   = 8'h14;
  localparam logic [7:0]  RST_STATUS     = 8'h00;
  localparam logic [15:0] RST_FW         = 16'h0000;

  // ************************************************************
  // complete state of the checker
  // ************************************************************
  typedef struct packed {
    logic [7:0]  statusHigh;
    logic [15:0] fwLow;
    logic [15:0] fwHigh;
    logic        ack;
    logic [31:0] wbData;
    logic [7:0]  sfrData;
    logic [15:0] denyCount;
    logic [16:0] lastDeny;
  } mbac_state_t;

endpackage : mbac_pkg
`default_nettype wire

// ### verilog/mbac_mem_check.sv
`timescale 1ns/10ps
`default_nettype none
module mbac_mem_check
(
  input  wire logic                 coproc,
  input  wire mbac_pkg::mbac_mode_t mode,
  input  wire mbac_pkg::mbac_space_t space,
  input  wire mbac_pkg::mbac_op_t   op,
  input  wire logic [15:0]          virtAddr,
  output logic                      permit,
  output logic [15:0]               physAddr
);

  logic [2:0]  rights;
  logic [15:0] base;
  logic [16:0] size;

  // ************************************************************
  // partition and rights lookup, rights are {fetch, write, read}
  // ************************************************************
  // partitions are constants: nothing can reconfigure them
  always_comb
  begin
    rights = 3'h0;
    base   = 16'h0000;
    size   = 17'h00000;
    if (coproc)
    begin
      if (space == mbac_pkg::SP_EEPROM)
      begin
        rights = 3'h1;
        size   = mbac_pkg::EE_WHOLE_SIZE;
      end
      else if (space == mbac_pkg::SP_CRAM)
      begin
        rights = 3'h3;
        base   = mbac_pkg::CRAM_BASE;
        size   = mbac_pkg::CRAM_SIZE;
      end
    end
    else
    begin
      case (space)
        mbac_pkg::SP_ROM:
        begin
          rights = 3'h5;
          if (mode == mbac_pkg::MODE_TEST)
            size = mbac_pkg::ROM_WHOLE_SIZE;
          else if (mode == mbac_pkg::MODE_SYS)
          begin
            base = mbac_pkg::ROM_APP_BASE;
            size = mbac_pkg::ROM_APP_SIZE;
          end
          else
          begin
            base = mbac_pkg::ROM_TEST_BASE;
            size = mbac_pkg::ROM_TEST_SIZE;
          end
        end
        mbac_pkg::SP_EEPROM:
        begin
          rights = 3'h7;
          if (mode == mbac_pkg::MODE_TEST)
            size = mbac_pkg::EE_WHOLE_SIZE;
          else if (mode == mbac_pkg::MODE_SYS)
          begin
            base = mbac_pkg::EE_APP_BASE;
            size = mbac_pkg::EE_APP_SIZE;
          end
          else
          begin
            base = mbac_pkg::EE_ISO_BASE;
            size = mbac_pkg::EE_ISO_SIZE;
          end
        end
        mbac_pkg::SP_SECROW:
        begin
          base = mbac_pkg::EE_SEC_BASE;
          size = mbac_pkg::EE_SEC_SIZE;
          case (mode)
            mbac_pkg::MODE_BOOT: rights = 3'h3;
            mbac_pkg::MODE_TEST: rights = 3'h7;
            mbac_pkg::MODE_ISO:  rights = 3'h1;
            default:             rights = 3'h0;
          endcase
        end
        mbac_pkg::SP_RAM:
        begin
          rights = (mode == mbac_pkg::MODE_ISO) ? 3'h0 : 3'h3;
          if (mode == mbac_pkg::MODE_TEST)
            size = mbac_pkg::RAM_WHOLE_SIZE;
          else if (mode == mbac_pkg::MODE_SYS)
          begin
            base = mbac_pkg::RAM_APP_BASE;
            size = mbac_pkg::RAM_APP_SIZE;
          end
          else
          begin
            base = mbac_pkg::RAM_BOOT_BASE;
            size = mbac_pkg::RAM_BOOT_SIZE;
          end
        end
        default:
          rights = 3'h0;
      endcase
    end
  end

  // ************************************************************
  // translation and bound check
  // ************************************************************
  // virtual to physical, checked first
  assign physAddr = base + virtAddr;
  assign permit   = rights[op] && ({1'b0, virtAddr} < size) && (op != 2'b11);

endmodule : mbac_mem_check
`default_nettype wire

// ### verilog/mbac_checker.sv
// Function
// - Test mode: whole ROM read/fetch, whole EEPROM all, whole RAM read/write.
// - Isolated mode: test ROM, isolated EEPROM, no RAM at all.
// - System mode: application ROM, EEPROM and RAM partitions only.
// - Security rows: read/write in boot mode, read-only in isolated mode.
// - Coprocessor: EEPROM read-only, own RAM read/write.
// - Boot and test modes reach every register group.
// - Isolated mode: firewall registers free, hardware registers per firewall bits.
// - System mode: system, firewall, hardware groups; test group denied.
// - General CPU registers are open in every mode.
// - High status word readable in isolated mode.
// - Clock select readable in isolated mode regardless of firewall.
// - The three system pointers are never readable.
// - Random number register is read-only; writes do nothing.
// - Hidden key register is never readable.
// - Reset partitions block everything outside the mode; not configurable.
// - Security attribute reset values cannot be overridden.
// - Security attributes change only from modes with write right.
// - Denied reads return zero, denied writes are dropped.
// - Boot mode: test ROM, isolated EEPROM, boot RAM.
// - Mode comes from high status word plus two internal bits.
// - Addresses are translated, and checked before memory is touched.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module mbac_checker
#(
  parameter int ADR_W = 8
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  // classic wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // internal mode bits from the core
  input  wire logic                  bootFlag,
  input  wire logic                  testFlag,
  // memory request from the core or coprocessor
  input  wire logic                  memReq,
  input  wire logic                  memCoproc,
  input  wire mbac_pkg::mbac_space_t memSpace,
  input  wire mbac_pkg::mbac_op_t    memOp,
  input  wire logic [15:0]           memVirtAddr,
  output logic                       memPermit,
  output logic                       memGo,
  output logic [15:0]                memPhysAddr,
  // special function register request from the core
  input  wire logic                  sfrReq,
  input  wire logic                  sfrWrite,
  input  wire logic [7:0]            sfrAddr,
  input  wire logic [7:0]            sfrWdata,
  input  wire logic [7:0]            sfrStoreRdata,
  output logic                       sfrPermit,
  output logic                       sfrWriteEn,
  output logic [7:0]                 sfrRdata,
  output mbac_pkg::mbac_mode_t       cpuMode
);

  // ************************************************************
  // register group decode
  // ************************************************************
  function automatic mbac_pkg::mbac_group_t sfr_group(input logic [7:0] a);
    if (a < mbac_pkg::SFR_GEN_LO)
      return mbac_pkg::GRP_NONE;
    else if (a < mbac_pkg::SFR_SYS_LO)
      return mbac_pkg::GRP_GEN;
    else if (a < mbac_pkg::SFR_FW_LO)
      return mbac_pkg::GRP_SYS;
    else if (a < mbac_pkg::SFR_HW_LO)
      return mbac_pkg::GRP_FW;
    else if (a < mbac_pkg::SFR_TEST_LO)
      return mbac_pkg::GRP_HW;
    else
      return mbac_pkg::GRP_TEST;
  endfunction : sfr_group

  // ************************************************************
  // register permission, shared by core and bus paths
  // ************************************************************
  function automatic logic sfr_allowed(
    input mbac_pkg::mbac_mode_t m,
    input logic [7:0]           a,
    input logic                 wr,
    input logic [31:0]          fw
  );
    mbac_pkg::mbac_group_t g;
    logic                  ok;
    g  = sfr_group(a);
    ok = 1'b0;
    case (m)
      mbac_pkg::MODE_BOOT,
      mbac_pkg::MODE_TEST:
        ok = (g != mbac_pkg::GRP_NONE);
      mbac_pkg::MODE_ISO:
      begin
        if (g == mbac_pkg::GRP_FW)
          ok = 1'b1;
        else if (g == mbac_pkg::GRP_HW)
          ok = fw[a[4:0]];
        if (a == mbac_pkg::SFR_STATUS_HIGH && !wr)
          ok = 1'b1;
        if (a == mbac_pkg::SFR_CLOCK_SEL && !wr)
          ok = 1'b1;
      end
      mbac_pkg::MODE_SYS:
        ok = (g == mbac_pkg::GRP_SYS) || (g == mbac_pkg::GRP_FW) ||
             (g == mbac_pkg::GRP_HW);
      default:
        ok = 1'b0;
    endcase
    if (g == mbac_pkg::GRP_GEN)
      ok = 1'b1;
    if (!wr && a >= mbac_pkg::SFR_POINTER_0 && a <= mbac_pkg::SFR_POINTER_2)
      ok = 1'b0;
    if (wr && a == mbac_pkg::SFR_RANDOM)
      ok = 1'b0;
    if (!wr && a == mbac_pkg::SFR_HIDDEN_KEY)
      ok = 1'b0;
    return ok;
  endfunction : sfr_allowed

  // ************************************************************
  // state and derived signals
  // ************************************************************
  mbac_pkg::mbac_state_t stateQ;
  mbac_pkg::mbac_state_t stateD;
  mbac_pkg::mbac_mode_t  mode;
  logic [31:0]           fwRights;
  logic                  memOk;
  logic                  sfrOk;
  logic                  sfrLocal;
  logic                  wbReq;
  logic [7:0]            wbOff;
  logic                  wbStatusWrOk;
  logic                  wbFwWrOk;
  logic                  denyEvt;

  // internal bits first, then the status word
  always_comb
  begin
    if (bootFlag)
      mode = mbac_pkg::MODE_BOOT;
    else if (testFlag)
      mode = mbac_pkg::MODE_TEST;
    else if (stateQ.statusHigh[mbac_pkg::STATUS_ISO_BIT])
      mode = mbac_pkg::MODE_ISO;
    else
      mode = mbac_pkg::MODE_SYS;
  end

  assign fwRights = {stateQ.fwHigh, stateQ.fwLow};
  assign cpuMode  = mode;

  mbac_mem_check u_mem_check
  (
    .coproc   (memCoproc),
    .mode     (mode),
    .space    (memSpace),
    .op       (memOp),
    .virtAddr (memVirtAddr),
    .permit   (memOk),
    .physAddr (memPhysAddr)
  );

  // same-cycle decisions gate the storage strobes
  assign memPermit  = memOk;
  assign memGo      = memReq && memOk;
  assign sfrOk      = sfr_allowed(mode, sfrAddr, sfrWrite, fwRights);
  assign sfrPermit  = sfrOk;
  // attribute registers live here, the rest in outside storage
  assign sfrLocal   = (sfrAddr == mbac_pkg::SFR_STATUS_HIGH) ||
                      (sfrAddr == mbac_pkg::SFR_FW_CTRL_LOW) ||
                      (sfrAddr == mbac_pkg::SFR_FW_CTRL_HI);
  // a denied write never reaches storage
  assign sfrWriteEn = sfrReq && sfrWrite && sfrOk && !sfrLocal;

  // bus side needs the same write right as the core would
  assign wbReq        = wb_cyc_i && wb_stb_i && !stateQ.ack;
  assign wbOff        = {wb_adr_i[7:2], 2'b00};
  assign wbStatusWrOk = sfr_allowed(mode, mbac_pkg::SFR_STATUS_HIGH, 1'b1, fwRights);
  assign wbFwWrOk     = sfr_allowed(mode, mbac_pkg::SFR_FW_CTRL_LOW, 1'b1, fwRights);
  assign denyEvt      = (memReq && !memOk) || (sfrReq && !sfrOk);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    stateD     = stateQ;
    stateD.ack = wbReq;
    // core writes to local attribute registers
    // only with write right
    if (sfrReq && sfrWrite && sfrOk)
    begin
      if (sfrAddr == mbac_pkg::SFR_STATUS_HIGH)
        stateD.statusHigh = sfrWdata;
      if (sfrAddr == mbac_pkg::SFR_FW_CTRL_LOW)
        stateD.fwLow[7:0] = sfrWdata;
      if (sfrAddr == mbac_pkg::SFR_FW_CTRL_HI)
        stateD.fwHigh[7:0] = sfrWdata;
    end
    // core read data, registered one cycle after the request
    // denied read returns zero
    if (sfrReq && !sfrWrite)
    begin
      if (!sfrOk)
        stateD.sfrData = 8'h00;
      else if (sfrAddr == mbac_pkg::SFR_STATUS_HIGH)
        stateD.sfrData = stateQ.statusHigh;
      else if (sfrAddr == mbac_pkg::SFR_FW_CTRL_LOW)
        stateD.sfrData = stateQ.fwLow[7:0];
      else if (sfrAddr == mbac_pkg::SFR_FW_CTRL_HI)
        stateD.sfrData = stateQ.fwHigh[7:0];
      else
        stateD.sfrData = sfrStoreRdata;
    end
    // bus writes; the bus wins over a core write in the same cycle
    if (wbReq && wb_we_i)
    begin
      case (wbOff)
        mbac_pkg::WB_STATUS_HIGH:
          if (wbStatusWrOk && wb_sel_i[0])
            stateD.statusHigh = wb_dat_i[7:0];
        mbac_pkg::WB_FW_LOW:
        begin
          if (wbFwWrOk && wb_sel_i[0])
            stateD.fwLow[7:0] = wb_dat_i[7:0];
          if (wbFwWrOk && wb_sel_i[1])
            stateD.fwLow[15:8] = wb_dat_i[15:8];
        end
        mbac_pkg::WB_FW_HIGH:
        begin
          if (wbFwWrOk && wb_sel_i[0])
            stateD.fwHigh[7:0] = wb_dat_i[7:0];
          if (wbFwWrOk && wb_sel_i[1])
            stateD.fwHigh[15:8] = wb_dat_i[15:8];
        end
        mbac_pkg::WB_DENY_COUNT:
          stateD.denyCount = 16'h0000;
        default:
          stateD.denyCount = stateD.denyCount;
      endcase
    end
    // denial counter saturates; a denial in the cycle of a clear counts from zero
    if (denyEvt)
    begin
      if (stateD.denyCount != 16'hFFFF)
        stateD.denyCount = stateD.denyCount + 16'h0001;
      stateD.lastDeny = (memReq && !memOk) ? {1'b0, memVirtAddr} :
                                             {1'b1, 8'h00, sfrAddr};
    end
    // bus read data
    stateD.wbData = 32'h0000_0000;
    if (wbReq && !wb_we_i)
    begin
      case (wbOff)
        mbac_pkg::WB_STATUS_HIGH: stateD.wbData = {24'h000000, stateQ.statusHigh};
        mbac_pkg::WB_FW_LOW:      stateD.wbData = {16'h0000, stateQ.fwLow};
        mbac_pkg::WB_FW_HIGH:     stateD.wbData = {16'h0000, stateQ.fwHigh};
        mbac_pkg::WB_MODE:        stateD.wbData = {28'h0000000, testFlag, bootFlag, mode};
        mbac_pkg::WB_DENY_COUNT:  stateD.wbData = {16'h0000, stateQ.denyCount};
        mbac_pkg::WB_LAST_DENY:   stateD.wbData = {15'h0000, stateQ.lastDeny};
        default:                  stateD.wbData = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // fixed restrictive reset, no input can preset it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stateQ            <= '0;
      stateQ.statusHigh <= mbac_pkg::RST_STATUS;
      stateQ.fwLow      <= mbac_pkg::RST_FW;
      stateQ.fwHigh     <= mbac_pkg::RST_FW;
    end
    else
      stateQ <= stateD;
  end

  assign wb_ack_o = stateQ.ack;
  assign wb_dat_o = stateQ.wbData;
  assign sfrRdata = stateQ.sfrData;

endmodule : mbac_checker
`default_nettype wire

// ### bench/mbac_sfr_store.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// register storage
// ********************
module mbac_sfr_store
(
  input  wire logic       clk,
  input  wire logic       writeEn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata
);
  logic [7:0] cells [256];

  // distinct start values so a read of the wrong cell shows up
  initial for (int i = 0; i < 256; i++) cells[i] = 8'(i) ^ 8'h5A;

  // only a granted write may touch storage
  always @(posedge clk) if (writeEn) cells[addr] <= wdata;

  // contents appear in the same cycle as the address
  assign rdata = cells[addr];
endmodule : mbac_sfr_store
`default_nettype wire

// ### bench/mbac_checker_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// access rule checks
// ********************
module mbac_checker_monitor
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  memReq,
  input wire logic                  memCoproc,
  input wire mbac_pkg::mbac_space_t memSpace,
  input wire mbac_pkg::mbac_op_t    memOp,
  input wire logic                  memPermit,
  input wire logic                  memGo,
  input wire logic                  sfrReq,
  input wire logic                  sfrWrite,
  input wire logic [7:0]            sfrAddr,
  input wire logic                  sfrPermit,
  input wire logic                  sfrWriteEn,
  input wire logic [7:0]            sfrRdata,
  input wire mbac_pkg::mbac_mode_t  cpuMode
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  // a register read asked for in this cycle
  sequence s_readReq;
    sfrReq && !sfrWrite;
  endsequence

  a_go_permit: assert property (memGo == (memReq && memPermit))
    else $error("memory go does not follow permit");
  a_iso_ram: assert property (!memCoproc && cpuMode == 2'h2 && memSpace == 3'h2 |-> !memPermit)
    else $error("isolated mode reached ram");
  a_rom_write: assert property (memSpace == 3'h0 && memOp == 2'h1 |-> !memPermit)
    else $error("rom write permitted");
  a_coproc_ee: assert property (memCoproc && memSpace == 3'h1 && memOp != 2'h0 |-> !memPermit)
    else $error("coprocessor eeprom write or fetch permitted");
  a_denied_zero: assert property (s_readReq ##0 !sfrPermit |=> sfrRdata == 8'h00)
    else $error("denied register read returned data");
  a_hidden_read: assert property (s_readReq ##0 sfrAddr inside {[8'hA1:8'hA3], 8'hD2} |-> !sfrPermit)
    else $error("hidden register readable");
  a_random_ro: assert property (sfrWrite && sfrAddr == 8'hD1 |-> !sfrWriteEn)
    else $error("random register written");
  a_general_open: assert property (sfrReq && sfrAddr inside {[8'h80:8'h9F]} |-> sfrPermit)
    else $error("general register denied");
endmodule : mbac_checker_monitor

bind mbac_checker mbac_checker_monitor u_mon (.clk, .rst, .memReq, .memCoproc, .memSpace,
  .memOp, .memPermit, .memGo, .sfrReq, .sfrWrite, .sfrAddr, .sfrPermit, .sfrWriteEn,
  .sfrRdata, .cpuMode);
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// access checker bench
// ********************
module testbench;
  logic                  clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic                  bootF = 1'b0, testF = 1'b0, memReq = 1'b0, coproc = 1'b0, permit, go;
  logic                  sfrReq = 1'b0, sfrWr = 1'b0, sfrPermit, sfrWe, rdPend = 1'b0;
  logic [7:0]            adr = 8'h00, sAddr = 8'h00, sWd = 8'h00, sStore, sRd, ra, stat;
  logic [15:0]           vAddr = 16'h0000, phys;
  logic [31:0]           wDat = 32'h0, rDat, fw, wbQ[$], sfrQ[$], memQ[$];
  mbac_pkg::mbac_space_t space = mbac_pkg::SP_ROM;
  mbac_pkg::mbac_op_t    op = mbac_pkg::OP_READ;
  mbac_pkg::mbac_mode_t  mode;
  int                    n_mismatch = 0, samples_checked = 0;
  localparam logic [15:0] AV [8] = '{16'h007F, 16'h0080, 16'h00FF, 16'h0100, 16'h01FF,
                                     16'h0200, 16'h0FFF, 16'h1000};
  localparam logic [7:0]  SL [10] = '{8'h10, 8'h85, 8'hA0, 8'hA2, 8'hB4, 8'hC5, 8'hD0,
                                      8'hD1, 8'hD2, 8'hF3};
  localparam logic [16:0] SZ [3][4] = '{'{17'h02000, 17'h10000, 17'h02000, 17'h0E000},
    '{17'h01000, 17'h10000, 17'h01000, 17'h0EF80}, '{17'h00100, 17'h01000, 17'h00000, 17'h00F00}};
  localparam logic [15:0] SB [3] = '{16'h2000, 16'h1080, 16'h0100};

  mbac_checker dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wDat), .wb_dat_o(rDat), .wb_ack_o(ack),
    .bootFlag(bootF), .testFlag(testF), .memReq(memReq), .memCoproc(coproc), .memSpace(space),
    .memOp(op), .memVirtAddr(vAddr), .memPermit(permit), .memGo(go), .memPhysAddr(phys),
    .sfrReq(sfrReq), .sfrWrite(sfrWr), .sfrAddr(sAddr), .sfrWdata(sWd), .sfrStoreRdata(sStore),
    .sfrPermit(sfrPermit), .sfrWriteEn(sfrWe), .sfrRdata(sRd), .cpuMode(mode));
  mbac_sfr_store store (.clk(clk), .writeEn(sfrWe), .addr(sAddr), .wdata(sWd), .rdata(sStore));

  initial forever #2 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // watcher: takes the oldest note whenever a result shows
  always @(posedge clk)
  begin
    if (memReq) check({15'h0, permit, permit ? phys : 16'h0}, memQ.pop_front());
    if (ack && !we) check(rDat, wbQ.pop_front());
    if (rdPend) check(32'(sRd), sfrQ.pop_front());
    rdPend <= sfrReq && !sfrWr;
  end

  // classic bus cycle, held until ack; no latency assumed
  task automatic wbCyc(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wDat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wbCyc

  task automatic wbRd(input logic [7:0] a, input logic [31:0] e);
    wbQ.push_back(e);
    wbCyc(1'b0, a, 32'h0);
  endtask : wbRd

  // boot flag first, so the status word may always be written
  task automatic setMode(input logic [1:0] m);
    bootF <= 1'b1;
    testF <= 1'b0;
    @(posedge clk);
    stat = m == 2'h2 ? 8'h80 : 8'h00;
    wbCyc(1'b1, 8'h00, 32'(stat));
    bootF <= m == 2'h0;
    testF <= m == 2'h1;
    @(posedge clk);
    check(32'(mode), 32'(m));
    wbRd(8'h0C, {28'h0, m == 2'h1, m == 2'h0, m});
  endtask : setMode

  // expected permit and physical address for one memory try
  task automatic memTry(input logic [1:0] m, input logic c, input logic [2:0] s,
                        input logic [1:0] o, input logic [15:0] a);
    logic        ok;
    logic [15:0] b;
    logic [16:0] sz;
    b = 16'h0000;
    sz = s == 3'h4 ? 17'h00200 : 17'h10000;
    ok = o != 2'h3;
    if (c)
      ok = ok && (s == 3'h1 ? o == 2'h0 : s == 3'h4 && o != 2'h2);
    else if (s < 3'h3)
    begin
      sz = SZ[s][m];
      b = m == 2'h3 ? SB[s] : 16'h0000;
      ok = ok && !(s == 3'h0 && o == 2'h1) && !(s == 3'h2 && o == 2'h2);
    end
    else
    begin
      sz = 17'h00080;
      b = 16'h1000;
      ok = ok && s == 3'h3 && m != 2'h3 && (m == 2'h1 || o != 2'h2) && (m != 2'h2 || o == 2'h0);
    end
    ok = ok && {1'b0, a} < sz;
    memReq <= 1'b1;
    coproc <= c;
    space <= mbac_pkg::mbac_space_t'(s);
    op <= mbac_pkg::mbac_op_t'(o);
    vAddr <= a;
    memQ.push_back({15'h0, ok, ok ? b + a : 16'h0000});
    @(posedge clk);
  endtask : memTry

  function automatic logic [31:0] sfrExp(input logic [1:0] m, input logic [7:0] a);
    logic ok;
    ok = a >= 8'hA0 && m < 2'h2 || a inside {[8'h80:8'h9F]} || m == 2'h3 && a inside
      {[8'hA0:8'hEF]} || m == 2'h2 && (a inside {8'hA0, 8'hD0} || a[7:4] == 4'hC
      || a inside {[8'hD0:8'hEF]} && fw[a[4:0]]);
    ok = ok && !(a inside {[8'hA1:8'hA3], 8'hD2});
    return ok ? 32'(a == 8'hA0 ? stat : a ^ 8'h5A) : 32'h0;
  endfunction : sfrExp

  // register request held high across back-to-back calls
  task automatic sfrAcc(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input logic [31:0] e);
    sfrReq <= 1'b1;
    sfrWr <= w;
    sAddr <= a;
    sWd <= d;
    if (!w) sfrQ.push_back(e);
    @(posedge clk);
  endtask : sfrAcc

  // main sequence: reset, sweep per mode, then directed writes
  initial
  begin
    void'($urandom(55938));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 7; k++) wbRd(8'(4 * k), k == 3 ? 32'h3 : 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      setMode(2'(m));
      fw = $urandom;
      wbCyc(1'b1, 8'h04, {16'h0, fw[15:0]});
      wbCyc(1'b1, 8'h08, {16'h0, fw[31:16]});
      wbRd(8'h04, {16'h0, fw[15:0]});
      for (int c = 0; c < 40; c++)
        for (int k = 0; k < 10; k++)
          memTry(2'(m), c[0], 3'(c / 8), c[2:1], k < 8 ? AV[k] : 16'($urandom));
      memReq <= 1'b0;
      for (int k = 0; k < 16; k++)
      begin
        ra = k < 10 ? SL[k] : 8'hD0 + 8'($urandom % 32);
        sfrAcc(1'b0, ra, 8'h00, sfrExp(2'(m), ra));
      end
      sfrReq <= 1'b0;
    end
    // system mode: denied write, then a core write enters isolated mode
    sfrAcc(1'b1, 8'hF3, 8'hAA, 32'h0);
    sfrAcc(1'b1, 8'hA0, 8'h80, 32'h0);
    sfrAcc(1'b0, 8'hA0, 8'h00, 32'h80);
    sfrAcc(1'b1, 8'hA0, 8'h00, 32'h0);
    sfrAcc(1'b0, 8'hA0, 8'h00, 32'h80);
    sfrReq <= 1'b0;
    wbCyc(1'b1, 8'h00, 32'h0);
    wbRd(8'h00, 32'h80);
    setMode(2'h0);
    sfrAcc(1'b1, 8'hD1, 8'h55, 32'h0);
    sfrAcc(1'b1, 8'h85, 8'h3C, 32'h0);
    sfrAcc(1'b0, 8'hD1, 8'h00, 32'h8B);
    sfrAcc(1'b0, 8'h85, 8'h00, 32'h3C);
    sfrAcc(1'b0, 8'hF3, 8'h00, 32'hA9);
    sfrReq <= 1'b0;
    wbRd(8'h14, 32'h100D1);
    repeat (3) @(posedge clk);
    check(32'(wbQ.size() + sfrQ.size() + memQ.size()), 32'h0);
    results();
  end

  // watchdog: the whole run needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule : testbench
`default_nettype wire
